// ===== logic/hrs_params.svh
// Constants for the hub reset and configuration sequencer.
// Assumes a 20 MHz core clock; all cycle counts but the fixed strap sample count derive from it.
`ifndef HRS_PARAMS_SVH
`define HRS_PARAMS_SVH

// ============================================================
// Clock and counter width
`define HRS_CLK_MHZ          20
`define HRS_CNT_W            22

// ============================================================
// Times as printed, in their own units
`define HRS_T_RECOVERY_US    500
`define HRS_T_LOAD_MAX_US    99500
`define HRS_T_REQ_MAX_US     5000
`define HRS_T_PWR_UNIT_US    2000
`define HRS_T_STRAP_HOLD_NS  1400

// ============================================================
// Cycle counts derived from the times (the ns strap hold rounds down), plus a fixed strap sample count
`define HRS_RECOVERY_CYC     (`HRS_T_RECOVERY_US * `HRS_CLK_MHZ)
`define HRS_LOAD_MAX_CYC     (`HRS_T_LOAD_MAX_US * `HRS_CLK_MHZ)
`define HRS_REQ_MAX_CYC      (`HRS_T_REQ_MAX_US * `HRS_CLK_MHZ)
`define HRS_PWR_UNIT_CYC     (`HRS_T_PWR_UNIT_US * `HRS_CLK_MHZ)
`define HRS_STRAP_CYC        ((`HRS_T_STRAP_HOLD_NS * `HRS_CLK_MHZ) / 1000)
`define HRS_STRAP_SAMPLE     5'h03

// ============================================================
// Register map
`define HRS_REG_PWR_ON_DLY   8'h10
`define HRS_PWR_ON_DLY_RST   8'h00
`define HRS_PWR_ON_DLY_DEF   8'h32
`define HRS_RD_UNDEF         8'h00

// ============================================================
// Configuration select pin codes
`define HRS_SEL_DEFAULT      3'h0
`define HRS_SEL_STRAP        3'h1
`define HRS_SEL_EEPROM       3'h2
`define HRS_SEL_SMBUS        3'h3

`define HRS_PORTS            4
`define HRS_ADDR_ZERO        7'h00

`endif

// ===== logic/hrs_pkg.sv
// Types for the hub reset and configuration sequencer.
// Assumes hrs_params.svh supplies the numeric constants.
package hrs_pkg;

    // ============================================================
    // Start-up sequence, Gray coded along the usual path
    typedef enum logic [2:0] {
        HRS_ST_STRAP   = 3'h0,
        HRS_ST_RECOVER = 3'h1,
        HRS_ST_LOAD    = 3'h3,
        HRS_ST_ATTACH  = 3'h2,
        HRS_ST_RUN     = 3'h6
    } hrs_state_t;

    // ============================================================
    // Configuration source
    typedef enum logic [1:0] {
        HRS_MODE_DEFAULT = 2'h0,
        HRS_MODE_STRAP   = 2'h1,
        HRS_MODE_EEPROM  = 2'h2,
        HRS_MODE_SMBUS   = 2'h3
    } hrs_mode_t;

endpackage

// ===== logic/hrs_port_if.sv
// Link between the sequencer and one port power-on timer.
// Assumes both ends share clk and rst.
`timescale 1ns/1ps
interface hrs_port_if;
    logic       run;
    logic [7:0] delay;
    logic       good;

    modport ctl (output run, output delay, input good);
    modport tmr (input run, input delay, output good);
endinterface

// ===== logic/hrs_port_timer.sv
// Power-on timer of one downstream port, counting in fixed units.
// Assumes run is synchronous to clk and delay is stable while run is high.
`timescale 1ns/1ps
`include "hrs_params.svh"
module hrs_port_timer #(
    parameter logic [`HRS_CNT_W-1:0] UNIT_CYC = `HRS_PWR_UNIT_CYC
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Sequencer side
    hrs_port_if.tmr   prt
);
    logic [`HRS_CNT_W-1:0] pre_r;
    logic [7:0]            units_r;
    logic                  run_d_r;
    logic                  good_r;

    // ============================================================
    // Unit prescaler and unit countdown
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pre_r   <= '0;
            units_r <= '0;
            run_d_r <= 1'b0;
            good_r  <= 1'b0;
        end else begin
            run_d_r <= prt.run;
            if (!prt.run) begin
                good_r <= 1'b0;
            end else if (!run_d_r) begin
                units_r <= prt.delay;
                pre_r   <= UNIT_CYC - 1'b1;
                good_r  <= 1'b0;
            end else if (units_r == 8'h00) begin
                good_r <= 1'b1;
            end else if (pre_r == '0) begin
                pre_r   <= UNIT_CYC - 1'b1;
                units_r <= units_r - 1'b1;
            end else begin
                pre_r <= pre_r - 1'b1;
            end
        end
    end

    assign prt.good = good_r;
endmodule // hrs_port_timer

// ===== logic/hrs_sequencer.sv
// Hub reset, configuration source selection and attach sequencing.
// Assumes straps and the bus reset come from pins; loader and request
// strobes come from logic on clk.
`timescale 1ns/1ps
`include "hrs_params.svh"

// Function
// - Hold an 8-bit port power-on delay in 2 ms units.
// - Reads of undefined register addresses return zero.
// - Writes to undefined register addresses change nothing and raise no error.
// - Strap mode uses strap values where straps apply, defaults elsewhere.
// - Sample both LED pins after reset release; use them in default modes.
// - Strap high drives LED active low; strap low drives it active high.
// - In reset: ports off, power removed, transceivers high impedance, transactions dropped; enables reset to zero, which is on for active-low switches.
// - Reset returns registers to defaults, stops oscillator and PLL, LEDs off; the delay register resets to 00h, with 32h loaded later in default modes.
// - Device becomes operational 500 us after reset release.
// - Once operational, start reading EEPROM configuration when selected.
// - Strap mode drives outputs inactive within about 1.5 us of release.
// - Strap and EEPROM modes attach within 100 ms of configuration done.
// - EEPROM mode recovers in 500 us, then configures within 99.5 ms.
// - SMBus load bounded at 99.5 ms when bus powered, host-timed when self powered.
// - Each host request completes within 5 ms after configuration.
// - Bus reset sets address zero and returns to unconfigured.
// - Bus reset removes port power, clears translator buffers, resumes if suspended.
// - Upstream bus reset is never forwarded downstream.
// - Configuration source chosen from the three select pins.
// - Polarity strap sets port power output active level.
module hrs_sequencer #(
    parameter logic [`HRS_CNT_W-1:0] RECOVERY_CYC = `HRS_RECOVERY_CYC,
    parameter logic [`HRS_CNT_W-1:0] LOAD_MAX_CYC = `HRS_LOAD_MAX_CYC,
    parameter logic [`HRS_CNT_W-1:0] REQ_MAX_CYC  = `HRS_REQ_MAX_CYC,
    parameter logic [`HRS_CNT_W-1:0] PWR_UNIT_CYC = `HRS_PWR_UNIT_CYC
) (
    // Clock and hardware reset
    input  wire logic                    clk,
    input  wire logic                    rst,
    // Strap pins
    input  wire logic [2:0]              cfg_sel_pin,
    input  wire logic                    port_power_polarity_pin,
    input  wire logic                    self_powered_pin,
    // LED pins, two-way
    input  wire logic [1:0]              led_in,
    output logic      [1:0]              led_out,
    output logic      [1:0]              led_oe_n,
    input  wire logic [1:0]              led_on,
    // Configuration register port
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    input  wire logic [7:0]              reg_addr,
    input  wire logic [7:0]              reg_wdata,
    output logic      [7:0]              reg_rdata,
    // Configuration loader
    output logic                         eeprom_start,
    input  wire logic                    eeprom_done,
    input  wire logic                    smbus_done,
    output logic                         load_timeout,
    // Upstream side
    input  wire logic                    usb_bus_reset_pin,
    output logic                         attach,
    output logic                         phy_hiz,
    output logic                         clk_run,
    output logic                         operational,
    input  wire logic                    set_address,
    input  wire logic [6:0]              new_address,
    input  wire logic                    set_configured,
    output logic      [6:0]              dev_address,
    output logic                         configured,
    input  wire logic                    suspended,
    output logic                         resume_req,
    output logic                         tt_clear,
    // Host requests
    input  wire logic                    req_start,
    input  wire logic                    req_done,
    output logic                         req_force_done,
    // Downstream ports
    input  wire logic [`HRS_PORTS-1:0]   port_power_req,
    output logic      [`HRS_PORTS-1:0]   port_power_enable,
    output logic      [`HRS_PORTS-1:0]   port_power_good,
    output logic                         downstream_reset
);

    // ============================================================
    // Pin synchronisers
    logic [2:0]                sel_s1_r,  sel_s2_r;
    logic                      pol_s1_r,  pol_s2_r;
    logic                      selfp_s1_r, selfp_s2_r;
    logic [1:0]                led_s1_r,  led_s2_r;
    logic                      busr_s1_r, busr_s2_r, busr_d_r;
    logic                      bus_reset_evt;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sel_s1_r   <= '0;
            sel_s2_r   <= '0;
            pol_s1_r   <= 1'b0;
            pol_s2_r   <= 1'b0;
            selfp_s1_r <= 1'b0;
            selfp_s2_r <= 1'b0;
            led_s1_r   <= '0;
            led_s2_r   <= '0;
            busr_s1_r  <= 1'b0;
            busr_s2_r  <= 1'b0;
            busr_d_r   <= 1'b0;
        end else begin
            sel_s1_r   <= cfg_sel_pin;
            sel_s2_r   <= sel_s1_r;
            pol_s1_r   <= port_power_polarity_pin;
            pol_s2_r   <= pol_s1_r;
            selfp_s1_r <= self_powered_pin;
            selfp_s2_r <= selfp_s1_r;
            led_s1_r   <= led_in;
            led_s2_r   <= led_s1_r;
            busr_s1_r  <= usb_bus_reset_pin;
            busr_s2_r  <= busr_s1_r;
            busr_d_r   <= busr_s2_r;
        end
    end

    assign bus_reset_evt = busr_s2_r & ~busr_d_r;

    // ============================================================
    // Start-up sequence
    hrs_pkg::hrs_state_t       state_r, state_nxt;
    hrs_pkg::hrs_mode_t        mode_r;
    logic [`HRS_CNT_W-1:0]     cnt_r;
    logic                      strap_done_r;
    logic                      load_ok;
    logic                      load_expired;
    logic                      bounded_load;

    // A bus-powered SMBus load is bounded; a self-powered one waits for its host.
    assign bounded_load = (mode_r == hrs_pkg::HRS_MODE_EEPROM) | ~selfp_s2_r;
    assign load_ok      = (mode_r == hrs_pkg::HRS_MODE_EEPROM) ? eeprom_done : smbus_done;
    assign load_expired = bounded_load & (cnt_r >= LOAD_MAX_CYC - 1'b1);

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            hrs_pkg::HRS_ST_STRAP: begin
                if (strap_done_r) begin
                    state_nxt = hrs_pkg::HRS_ST_RECOVER;
                end
            end
            hrs_pkg::HRS_ST_RECOVER: begin
                if (cnt_r >= RECOVERY_CYC - 1'b1) begin
                    if (mode_r == hrs_pkg::HRS_MODE_EEPROM || mode_r == hrs_pkg::HRS_MODE_SMBUS) begin
                        state_nxt = hrs_pkg::HRS_ST_LOAD;
                    end else begin
                        state_nxt = hrs_pkg::HRS_ST_ATTACH;
                    end
                end
            end
            hrs_pkg::HRS_ST_LOAD: begin
                if (load_ok || load_expired) begin
                    state_nxt = hrs_pkg::HRS_ST_ATTACH;
                end
            end
            hrs_pkg::HRS_ST_ATTACH: begin
                state_nxt = hrs_pkg::HRS_ST_RUN;
            end
            hrs_pkg::HRS_ST_RUN: begin
                state_nxt = hrs_pkg::HRS_ST_RUN;
            end
            default: begin
                state_nxt = hrs_pkg::HRS_ST_STRAP;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= hrs_pkg::HRS_ST_STRAP;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Interval counter restarts on each state change.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
        end else if (state_nxt != state_r) begin
            cnt_r <= '0;
        end else if (state_r != hrs_pkg::HRS_ST_RUN) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    // ============================================================
    // Strap capture, a few cycles after release so the synchronisers have settled
    logic [4:0]                strap_cnt_r;
    logic [1:0]                led_strap_r;
    logic                      pol_strap_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            strap_cnt_r  <= '0;
            strap_done_r <= 1'b0;
            led_strap_r  <= '0;
            pol_strap_r  <= 1'b0;
            mode_r       <= hrs_pkg::HRS_MODE_DEFAULT;
        end else if (!strap_done_r) begin
            strap_cnt_r <= strap_cnt_r + 1'b1;
            if (strap_cnt_r == `HRS_STRAP_SAMPLE) begin
                strap_done_r <= 1'b1;
                led_strap_r  <= led_s2_r;
                pol_strap_r  <= pol_s2_r;
                unique case (sel_s2_r)
                    `HRS_SEL_STRAP:  mode_r <= hrs_pkg::HRS_MODE_STRAP;
                    `HRS_SEL_EEPROM: mode_r <= hrs_pkg::HRS_MODE_EEPROM;
                    `HRS_SEL_SMBUS:  mode_r <= hrs_pkg::HRS_MODE_SMBUS;
                    default:         mode_r <= hrs_pkg::HRS_MODE_DEFAULT;
                endcase
            end
        end
    end

    // ============================================================
    // LED pins: released in reset, driven inactive right after the strap sample
    logic                      default_mode;
    logic [1:0]                led_active_low;

    assign default_mode   = (mode_r == hrs_pkg::HRS_MODE_DEFAULT) | (mode_r == hrs_pkg::HRS_MODE_STRAP);
    assign led_active_low = default_mode ? led_strap_r : 2'h0;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            led_oe_n <= 2'h3;
            led_out  <= 2'h0;
        end else if (strap_done_r) begin
            led_oe_n <= 2'h0;
            led_out  <= (operational ? led_on : 2'h0) ^ led_active_low;
        end
    end

    // ============================================================
    // Power-on delay register; everything else decodes as undefined
    logic [7:0]                pwr_dly_r;
    logic                      loading;
    logic                      reg_hit;

    assign loading = (state_r == hrs_pkg::HRS_ST_LOAD);
    assign reg_hit = (reg_addr == `HRS_REG_PWR_ON_DLY);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pwr_dly_r <= `HRS_PWR_ON_DLY_RST;
        end else if (state_r == hrs_pkg::HRS_ST_RECOVER && default_mode) begin
            pwr_dly_r <= `HRS_PWR_ON_DLY_DEF;
        end else if (reg_wr && reg_hit && loading) begin
            pwr_dly_r <= reg_wdata;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= `HRS_RD_UNDEF;
        end else if (reg_rd) begin
            reg_rdata <= reg_hit ? pwr_dly_r : `HRS_RD_UNDEF;
        end
    end

    // ============================================================
    // Loader start and timeout flag
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            eeprom_start <= 1'b0;
            load_timeout <= 1'b0;
        end else begin
            eeprom_start <= (state_r == hrs_pkg::HRS_ST_RECOVER) && (state_nxt == hrs_pkg::HRS_ST_LOAD)
                            && (mode_r == hrs_pkg::HRS_MODE_EEPROM);
            if (loading && load_expired && !load_ok) begin
                load_timeout <= 1'b1;
            end
        end
    end

    // ============================================================
    // Upstream state: clocks, transceivers, attach, address and configuration
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clk_run     <= 1'b0;
            phy_hiz     <= 1'b1;
            operational <= 1'b0;
            attach      <= 1'b0;
        end else begin
            clk_run     <= 1'b1;
            phy_hiz     <= (state_r != hrs_pkg::HRS_ST_RUN);
            operational <= (state_r != hrs_pkg::HRS_ST_STRAP) && (state_nxt != hrs_pkg::HRS_ST_RECOVER);
            attach      <= (state_nxt == hrs_pkg::HRS_ST_RUN);
        end
    end

    // Bus reset is an edge on the synchronised pin; the host keeps its own
    // 100 ms wait after attach, so no guard is kept here against an early one.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dev_address <= `HRS_ADDR_ZERO;
            configured  <= 1'b0;
            tt_clear    <= 1'b0;
            resume_req  <= 1'b0;
        end else begin
            tt_clear   <= bus_reset_evt;
            resume_req <= bus_reset_evt & suspended;
            if (bus_reset_evt) begin
                dev_address <= `HRS_ADDR_ZERO;
                configured  <= 1'b0;
            end else if (state_r == hrs_pkg::HRS_ST_RUN) begin
                if (set_address) begin
                    dev_address <= new_address;
                end
                if (set_configured) begin
                    configured <= 1'b1;
                end
            end
        end
    end

    assign downstream_reset = 1'b0;

    // ============================================================
    // Host request watchdog: a request left open too long is closed by force
    logic                      req_busy_r;
    logic [`HRS_CNT_W-1:0]     req_cnt_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            req_busy_r     <= 1'b0;
            req_cnt_r      <= '0;
            req_force_done <= 1'b0;
        end else begin
            req_force_done <= 1'b0;
            if (bus_reset_evt || req_done) begin
                req_busy_r <= req_start;
                req_cnt_r  <= '0;
            end else if (req_start) begin
                req_busy_r <= 1'b1;
                req_cnt_r  <= '0;
            end else if (req_busy_r) begin
                if (req_cnt_r >= REQ_MAX_CYC - 1'b1) begin
                    req_force_done <= 1'b1;
                    req_busy_r     <= 1'b0;
                end else begin
                    req_cnt_r <= req_cnt_r + 1'b1;
                end
            end
        end
    end

    // ============================================================
    // Downstream port power, one timer per port
    logic [`HRS_PORTS-1:0]     pwr_on_r;
    logic [`HRS_PORTS-1:0]     req_d_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pwr_on_r <= '0;
            req_d_r  <= '0;
        end else begin
            req_d_r <= port_power_req;
            if (bus_reset_evt || state_r != hrs_pkg::HRS_ST_RUN) begin
                pwr_on_r <= '0;
            end else begin
                pwr_on_r <= (pwr_on_r | (port_power_req & ~req_d_r)) & port_power_req;
            end
        end
    end

    // The polarity strap only becomes valid after the sample, so outputs sit
    // at zero until then; a board with active-low switches must pull them off.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            port_power_enable <= '0;
        end else if (strap_done_r) begin
            port_power_enable <= pol_strap_r ? pwr_on_r : ~pwr_on_r;
        end
    end

    for (genvar p = 0; p < `HRS_PORTS; p++) begin : g_port
        hrs_port_if pif ();

        assign pif.run   = pwr_on_r[p];
        assign pif.delay = pwr_dly_r;

        hrs_port_timer #(
            .UNIT_CYC (PWR_UNIT_CYC)
        ) u_timer (
            .clk (clk),
            .rst (rst),
            .prt (pif.tmr)
        );

        assign port_power_good[p] = pif.good;
    end

endmodule // hrs_sequencer

// ===== sim/hrs_sva.sv
// Port checker for the hub reset sequencer.
// Assumes a bind from the bench top and the bench recovery count.
`timescale 1ns/1ps
module hrs_sva #(parameter int REC = 20) (
    input wire logic       clk, rst, operational, attach, usb_bus_reset_pin, tt_clear, suspended, resume_req,
    input wire logic       eeprom_start, eeprom_done, smbus_done, configured, reg_rd, downstream_reset,
    input wire logic [2:0] cfg_sel_pin,
    input wire logic [7:0] reg_addr, reg_rdata,
    input wire logic [6:0] dev_address
);
    // ============================================================
    // Properties
    localparam int OPW = REC + 12;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_bus_rst; $rose(usb_bus_reset_pin); endsequence
    AST_OPR: assert property ($fell(rst) |-> (!operational)[*8] ##[1:OPW] operational)
        else $error("operational late or early");
    AST_ATT: assert property (operational && !attach && (eeprom_done || smbus_done) |-> ##[1:3] attach)
        else $error("no attach after load");
    AST_EES: assert property ($rose(operational) && cfg_sel_pin == 3'h2 |-> ##[0:3] eeprom_start)
        else $error("no loader start");
    AST_EEO: assert property (eeprom_start |-> cfg_sel_pin == 3'h2)
        else $error("loader start in wrong mode");
    AST_BRA: assert property (s_bus_rst |-> ##[1:6] dev_address == 7'h00 && !configured)
        else $error("address kept after bus reset");
    AST_TTC: assert property (s_bus_rst |-> ##[1:6] tt_clear)
        else $error("buffers not cleared");
    AST_RSM: assert property ($rose(usb_bus_reset_pin) && suspended |-> ##[1:6] resume_req)
        else $error("no resume after bus reset");
    AST_UND: assert property (reg_rd && reg_addr != 8'h10 |=> reg_rdata == 8'h00)
        else $error("undefined read not zero");
    AST_DSR: assert property (downstream_reset == 1'b0)
        else $error("bus reset forwarded");
endmodule // hrs_sva

// ===== sim/hrs_host_model.sv
// Upstream host and configuration loader stand-in.
// Assumes straps stay steady during a run.
`timescale 1ns/1ps
module hrs_host_model #(parameter int DLY = 12, parameter int HOLD = 300) (
    input wire logic       clk, rst, operational, attach,
    input wire logic [2:0] cfg_sel_pin,
    output logic           eeprom_done, smbus_done, usb_bus_reset_pin
);
    // ============================================================
    // Sequence
    initial {eeprom_done, smbus_done, usb_bus_reset_pin} = 3'h0;
    always begin
        wait (!rst && operational);
        repeat (DLY) @(negedge clk);
        eeprom_done = cfg_sel_pin == 3'h2;
        smbus_done = cfg_sel_pin == 3'h3;
        @(negedge clk);
        {eeprom_done, smbus_done} = 2'h0;
        wait (attach);
        // The attach wait is scaled down so a run stays short.
        repeat (HOLD) @(negedge clk);
        usb_bus_reset_pin = 1'b1;
        repeat (4) @(negedge clk);
        usb_bus_reset_pin = 1'b0;
        wait (rst);
    end
endmodule // hrs_host_model

// ===== sim/tb_hrs_sequencer.sv
// Bench for the hub reset sequencer over all four strap modes.
// Assumes the design, checker and host model are compiled first.
`timescale 1ns/1ps
module tb_hrs_sequencer;
    // ============================================================
    // Signals
    logic       clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, set_address = 0, port_power_polarity_pin = 0, rd_d = 0;
    logic       self_powered_pin = 0, suspended = 0, set_configured = 0, req_start = 0, req_done = 0;
    logic       eeprom_done, smbus_done, usb_bus_reset_pin, load_timeout, attach, phy_hiz, clk_run, operational;
    logic       configured, resume_req, tt_clear, req_force_done, downstream_reset, eeprom_start;
    logic [1:0] led_in, led_out, led_oe_n, led_on = 2'h1, strap = 2'h0;
    logic [2:0] cfg_sel_pin = 3'h0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d, q[$];
    logic [6:0] new_address = 7'h00, dev_address;
    logic [3:0] port_power_req = 4'h0, port_power_enable, port_power_good;
    int         n_fail = 0, total_checks = 0, seed = 11, t;
    hrs_sequencer #(.RECOVERY_CYC(22'h14), .LOAD_MAX_CYC(22'h32), .REQ_MAX_CYC(22'h1E), .PWR_UNIT_CYC(22'h4)) uut (
        .clk, .rst, .cfg_sel_pin, .port_power_polarity_pin, .self_powered_pin, .led_in, .led_out,
        .led_oe_n, .led_on, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .eeprom_start, .eeprom_done,
        .smbus_done, .load_timeout, .usb_bus_reset_pin, .attach, .phy_hiz, .clk_run, .operational, .set_address,
        .new_address, .set_configured, .dev_address, .configured, .suspended, .resume_req, .tt_clear,
        .req_start, .req_done, .req_force_done, .port_power_req, .port_power_enable,
        .port_power_good, .downstream_reset);
    hrs_host_model u_host (.clk, .rst, .operational, .attach, .cfg_sel_pin, .eeprom_done, .smbus_done,
        .usb_bus_reset_pin);
    // The strap resistor sets the LED pin only while the design is not driving it.
    assign led_in = (led_oe_n & strap) | (~led_oe_n & led_out);
    initial forever #25 clk = ~clk;
    // ============================================================
    // Tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d fails %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic wt(input int k);
        for (t = 0; t < 400; t++) begin
            @(negedge clk);
            if ((k == 0 && operational === 1'b1) || (k == 1 && attach === 1'b1) ||
                (k == 2 && port_power_good[0] === 1'b1) || (k == 3 && usb_bus_reset_pin === 1'b1)) return;
        end
        n_fail++;
        $display("ERROR %0t: wait %0d timed out", $time, k);
        end_of_test;
    endtask
    task automatic rw(input logic w, input logic [7:0] a, input logic [7:0] v, input logic [7:0] e);
        {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, v};
        if (!w) q.push_back(e);
        @(negedge clk);
    endtask
    always @(posedge clk) begin
        rd_d <= reg_rd;
        if (rd_d) chk(reg_rdata, q.pop_front());
    end
    // ============================================================
    // Sequence
    initial begin
        for (int m = 0; m < 4; m++) begin
            {cfg_sel_pin, strap, port_power_polarity_pin} = {m[2:0], 2'($random(seed)), m[0]};
            {self_powered_pin, suspended} = 2'(m);
            rst = 1'b1;
            repeat (6) @(negedge clk);
            chk({clk_run, phy_hiz, operational, attach, port_power_enable}, 8'h40);
            rst = 1'b0;
            wt(0);
            chk({clk_run, t >= 20 && t <= 26}, 8'h03);
            d = m > 1 ? 8'($random(seed)) & 8'h07 : 8'h32;
            if (m > 1) begin
                rw(1'b1, 8'h10, d, 8'h00);
                rw(1'b1, 8'h55, 8'hFF, 8'h00);
                rw(1'b0, 8'h10, 8'h00, d);
                rw(1'b0, 8'h55, 8'h00, 8'h00);
                {reg_wr, reg_rd} = 2'h0;
            end
            wt(1);
            chk({load_timeout, led_oe_n, led_out}, m < 2 ? led_on ^ strap : led_on);
            {set_address, set_configured, new_address} = {2'h3, 7'($random(seed))};
            @(negedge clk) {set_address, set_configured} = 2'h0;
            chk({dev_address, configured}, {new_address, 1'b1});
            req_start = 1'b1;
            @(negedge clk) req_start = 1'b0;
            repeat (29) @(negedge clk);
            req_done = m[1];
            chk(req_force_done, 8'h00);
            @(negedge clk) chk(req_force_done, !m[1]);
            req_done = 1'b0;
            port_power_req = 4'h1;
            wt(2);
            chk(t >= d * 4 && t <= d * 4 + 5, 8'h01);
            chk({phy_hiz, port_power_enable}, {4'h0, {3{!port_power_polarity_pin}}, port_power_polarity_pin});
            wt(3);
            repeat (8) @(negedge clk);
            chk({dev_address, configured}, 8'h00);
            chk({port_power_good, port_power_enable}, {4'h0, {4{!port_power_polarity_pin}}});
            port_power_req = 4'h0;
            $display("mode %0d done", m);
        end
        end_of_test;
    end
endmodule // tb_hrs_sequencer
bind hrs_sequencer hrs_sva #(.REC(20)) u_sva (.clk, .rst, .operational, .attach, .usb_bus_reset_pin, .tt_clear,
    .eeprom_start, .eeprom_done, .smbus_done, .configured, .reg_rd, .downstream_reset, .cfg_sel_pin,
    .reg_addr, .reg_rdata, .dev_address, .suspended, .resume_req);
